// >>> design/pmc_port_mode_ctrl_regs.sv
`include "pmc_map.svh"

module pmc_port_mode_ctrl_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire pmc_pkg::pmc_addr_type io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire pmc_pkg::pmc_byte_type io_wdata_in,
  output pmc_pkg::pmc_byte_type io_rdata_out,
  input wire logic global_irq_on_instr_in,
  input wire logic global_irq_off_instr_in,
  input wire pmc_pkg::pmc_byte_type irq_event_in,
  input wire pmc_pkg::pmc_byte_type irq_flag_clr_in,
  input wire logic wakeup_in,
  input wire logic udc_resume_in,
  input wire logic usb_device_controller_block_in,
  input wire logic watchdog_code_option_in,
  output pmc_pkg::pmc_byte_type port7_dir_out,
  output pmc_pkg::pmc_sink_type first_pin_drive_out,
  output pmc_pkg::pmc_sink_type second_pin_drive_out,
  output logic [2:0] debounce_degree_out,
  output logic [2:0] sample_rate_sel_out,
  output pmc_pkg::pmc_opmode_type op_mode_out,
  output pmc_pkg::pmc_slow_freq_type slow_freq_sel_out,
  output pmc_pkg::pmc_byte_type pull_low_select_out,
  output pmc_pkg::pmc_byte_type port6_pull_high_out,
  output pmc_pkg::pmc_byte_type pull_high_select_out,
  output logic pattern_detect_enable_out,
  output logic run_out,
  output logic watchdog_active_out,
  output logic port_wake_block_n_out,
  output logic dual_clock_normal_out,
  output pmc_pkg::pmc_byte_type irq_mask_out,
  output pmc_pkg::pmc_byte_type irq_flags_out,
  output logic irq_req_out
);
  import pmc_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  pmc_byte_type dir7;
  pmc_byte_type sink;
  pmc_byte_type pat;
  pmc_byte_type mode;
  pmc_byte_type pl6;
  pmc_byte_type ph6;
  pmc_byte_type ph7;
  pmc_byte_type sfr;
  pmc_byte_type imr;
  pmc_byte_type flags;
  pmc_byte_type rdata;
  logic gie;
  logic irq_req;
  logic wdt_active;
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic wtc_s1;
  logic wtc_s2;

  // ****************************************
  // Address decode
  // ****************************************
  wire logic wr_dir7 = io_wr_in && (io_addr_in == `PMC_ADDR_DIR7);
  wire logic wr_sink = io_wr_in && (io_addr_in == `PMC_ADDR_SINK);
  wire logic wr_pat = io_wr_in && (io_addr_in == `PMC_ADDR_PAT);
  wire logic wr_mode = io_wr_in && (io_addr_in == `PMC_ADDR_MODE);
  wire logic wr_pl6 = io_wr_in && (io_addr_in == `PMC_ADDR_PL6);
  wire logic wr_ph6 = io_wr_in && (io_addr_in == `PMC_ADDR_PH6);
  wire logic wr_ph7 = io_wr_in && (io_addr_in == `PMC_ADDR_PH7);
  wire logic wr_sfr = io_wr_in && (io_addr_in == `PMC_ADDR_SFR);
  wire logic wr_imr = io_wr_in && (io_addr_in == `PMC_ADDR_IMR);

  // Merge write data into writable bits only, fixed bits keep their value
  function automatic pmc_byte_type merge(input pmc_byte_type old_v, input pmc_byte_type new_v,
                                         input pmc_byte_type wmask);
    merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  wire pmc_byte_type next_dir7 = wr_dir7 ? io_wdata_in : dir7;
  wire pmc_byte_type next_sink = wr_sink ? merge(sink, io_wdata_in, `PMC_WM_SINK) : sink;
  wire pmc_byte_type next_pat = wr_pat ? merge(pat, io_wdata_in, `PMC_WM_PAT) : pat;
  wire pmc_byte_type next_mode = wr_mode ? merge(mode, io_wdata_in, `PMC_WM_MODE) : mode;
  wire pmc_byte_type next_pl6 = wr_pl6 ? merge(pl6, io_wdata_in, `PMC_WM_PORT6) : pl6;
  wire pmc_byte_type next_ph6 = wr_ph6 ? merge(ph6, io_wdata_in, `PMC_WM_PORT6) : ph6;
  wire pmc_byte_type next_ph7 = wr_ph7 ? io_wdata_in : ph7;
  wire pmc_byte_type next_imr = wr_imr ? io_wdata_in : imr;

  // ****************************************
  // Special function register
  // ****************************************
  // Hardware sets of run and wake block win over a firmware write
  wire logic wake_fall = wake_s3 && !wake_s2;
  wire logic resume_wake = udc_resume_in && !sfr[`PMC_SFR_RUN];
  wire pmc_byte_type sfr_written = wr_sfr ? merge(sfr, io_wdata_in, `PMC_WM_SFR) : sfr;
  wire logic next_run = sfr_written[`PMC_SFR_RUN] || wake_fall || resume_wake;
  wire logic next_wub = sfr_written[`PMC_SFR_WUB] || usb_device_controller_block_in;
  wire pmc_byte_type next_sfr = {sfr_written[7], next_wub, sfr_written[5], next_run, sfr_written[3:0]};

  // Watchdog runs only if both the enable bit and the code option allow it
  wire logic next_wdt_active = next_sfr[`PMC_SFR_WTE] && wtc_s2;

  // ****************************************
  // Interrupt flags and request
  // ****************************************
  wire logic slow_clock = !sfr[`PMC_SFR_DUAL];
  wire pmc_byte_type event_eff;
  wire pmc_byte_type next_flags;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (gi == `PMC_IRQ_HOST_RESUME) begin : g_resume
        assign event_eff[gi] = irq_event_in[gi] && slow_clock;
      end else begin : g_plain
        assign event_eff[gi] = irq_event_in[gi];
      end
      assign next_flags[gi] = event_eff[gi] || (flags[gi] && !irq_flag_clr_in[gi]);
    end
  endgenerate

  wire logic next_gie = global_irq_off_instr_in ? 1'b0 : (global_irq_on_instr_in ? 1'b1 : gie);
  wire logic next_irq_req = next_gie && |(next_flags & next_imr);

  // ****************************************
  // Read path
  // ****************************************
  pmc_byte_type read_mux;
  always_comb begin
    case (io_addr_in)
      `PMC_ADDR_DIR7: read_mux = dir7;
      `PMC_ADDR_SINK: read_mux = sink;
      `PMC_ADDR_PAT: read_mux = pat;
      `PMC_ADDR_MODE: read_mux = mode;
      `PMC_ADDR_PL6: read_mux = pl6;
      `PMC_ADDR_PH6: read_mux = ph6;
      `PMC_ADDR_PH7: read_mux = ph7;
      `PMC_ADDR_SFR: read_mux = sfr;
      `PMC_ADDR_IMR: read_mux = imr;
      default: read_mux = 8'h00;
    endcase
  end
  wire pmc_byte_type next_rdata = io_rd_in ? read_mux : rdata;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_s1 <= 1'b1;
      wake_s2 <= 1'b1;
      wake_s3 <= 1'b1;
      wtc_s1 <= 1'b0;
      wtc_s2 <= 1'b0;
    end else begin
      wake_s1 <= wakeup_in;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      wtc_s1 <= watchdog_code_option_in;
      wtc_s2 <= wtc_s1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir7 <= `PMC_RST_DIR7;
      sink <= `PMC_RST_SINK;
      pat <= `PMC_RST_PAT;
      mode <= `PMC_RST_MODE;
      pl6 <= `PMC_RST_PL6;
      ph6 <= `PMC_RST_PH6;
      ph7 <= `PMC_RST_PH7;
      sfr <= `PMC_RST_SFR;
      imr <= `PMC_RST_IMR;
    end else begin
      dir7 <= next_dir7;
      sink <= next_sink;
      pat <= next_pat;
      mode <= next_mode;
      pl6 <= next_pl6;
      ph6 <= next_ph6;
      ph7 <= next_ph7;
      sfr <= next_sfr;
      imr <= next_imr;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags <= 8'h00;
      gie <= `PMC_RST_GIE;
      irq_req <= 1'b0;
      wdt_active <= 1'b0;
      rdata <= 8'h00;
    end else begin
      flags <= next_flags;
      gie <= next_gie;
      irq_req <= next_irq_req;
      wdt_active <= next_wdt_active;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign io_rdata_out = rdata;
  assign port7_dir_out = dir7;
  assign first_pin_drive_out = pmc_sink_type'(sink[1:0]);
  assign second_pin_drive_out = pmc_sink_type'(sink[5:4]);
  assign debounce_degree_out = pat[2:0];
  assign sample_rate_sel_out = pat[6:4];
  assign op_mode_out = pmc_opmode_type'(mode[1:0]);
  assign slow_freq_sel_out = pmc_slow_freq_type'(mode[7:6]);
  assign pull_low_select_out = pl6;
  assign port6_pull_high_out = ph6;
  assign pull_high_select_out = ph7;
  assign pattern_detect_enable_out = sfr[`PMC_SFR_PDA];
  assign run_out = sfr[`PMC_SFR_RUN];
  assign watchdog_active_out = wdt_active;
  assign port_wake_block_n_out = sfr[`PMC_SFR_WUB];
  assign dual_clock_normal_out = sfr[`PMC_SFR_DUAL];
  assign irq_mask_out = imr;
  assign irq_flags_out = flags;
  assign irq_req_out = irq_req;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence wake_fall_seq;
    wake_s3 && !wake_s2;
  endsequence

  sequence sfr_clear_run_seq;
    wr_sfr && !io_wdata_in[`PMC_SFR_RUN] && !wake_fall && !resume_wake;
  endsequence

  dir_write_a: assert property (wr_dir7 |=> port7_dir_out == $past(io_wdata_in))
    else $error("port 7 direction did not take the written byte");

  sink_fixed_a: assert property ((sink & ~`PMC_WM_SINK) == 8'h00)
    else $error("sink register unused bits not zero");

  pat_fixed_a: assert property ((pat & 8'h88) == 8'h00 ##1 (pat & 8'h88) == 8'h00)
    else $error("pattern register bits 3 or 7 not zero");

  mode_fixed_a: assert property (wr_mode |=> mode[5:2] == 4'h0 && mode[1:0] == $past(io_wdata_in[1:0]))
    else $error("mode register write not masked properly");

  port6_bit0_a: assert property (wr_pl6 || wr_ph6 |=> pl6[0] == 1'b0 && ph6[0] == 1'b0)
    else $error("input-only pin got a pull resistor");

  run_wake_a: assert property (wake_fall_seq |=> run_out)
    else $error("run bit not set after wake falling edge");

  run_clear_a: assert property (sfr_clear_run_seq |=> !run_out)
    else $error("run bit not cleared by firmware write");

  wdt_option_a: assert property (!wtc_s2 |=> !watchdog_active_out)
    else $error("watchdog active while code option is zero");

  wake_block_a: assert property (usb_device_controller_block_in |=> port_wake_block_n_out)
    else $error("controller set of wake block lost");

  resume_slow_a: assert property (irq_event_in[`PMC_IRQ_HOST_RESUME] && !slow_clock &&
    !flags[`PMC_IRQ_HOST_RESUME] |=> !flags[`PMC_IRQ_HOST_RESUME])
    else $error("host resume flag set in normal clock mode");

  flag_hold_a: assert property (flags[0] && !irq_flag_clr_in[0] |=> flags[0])
    else $error("interrupt flag dropped without a clear");

  gie_block_a: assert property (global_irq_off_instr_in |=> !irq_req_out)
    else $error("interrupt requested after global disable");

  irq_mask_a: assert property (gie && |(flags & imr) && !global_irq_off_instr_in &&
    !wr_imr && irq_flag_clr_in == 8'h00 |=> irq_req_out)
    else $error("enabled pending interrupt not requested");

  sequence wdt_on_seq;
    wr_sfr && io_wdata_in[`PMC_SFR_WTE] && wtc_s2;
  endsequence

  sink_write_a: assert property (wr_sink |=> first_pin_drive_out == $past(io_wdata_in[1:0]) && second_pin_drive_out == $past(io_wdata_in[5:4]))
    else $error("sink current fields did not take the written codes");

  debounce_write_a: assert property (wr_pat |=> debounce_degree_out == $past(io_wdata_in[2:0]))
    else $error("debounce degree did not take the written code");

  rate_write_a: assert property (wr_pat |=> sample_rate_sel_out == $past(io_wdata_in[6:4]))
    else $error("sample rate did not take the written code");

  opmode_write_a: assert property (wr_mode |=> op_mode_out == $past(io_wdata_in[1:0]))
    else $error("operation mode did not take the written code");

  slow_write_a: assert property (wr_mode |=> slow_freq_sel_out == $past(io_wdata_in[7:6]))
    else $error("slow clock select did not take the written code");

  pl6_write_a: assert property (wr_pl6 |=> pull_low_select_out[7:1] == $past(io_wdata_in[7:1]))
    else $error("port 6 pull-low bits did not take the written byte");

  ph6_write_a: assert property (wr_ph6 |=> port6_pull_high_out[7:1] == $past(io_wdata_in[7:1]))
    else $error("port 6 pull-high bits did not take the written byte");

  ph7_write_a: assert property (wr_ph7 |=> pull_high_select_out == $past(io_wdata_in))
    else $error("port 7 pull-high bits did not take the written byte");

  pda_write_a: assert property (wr_sfr |=> pattern_detect_enable_out == $past(io_wdata_in[`PMC_SFR_PDA]))
    else $error("pattern detect enable did not take the written bit");

  wdt_on_a: assert property (wdt_on_seq |=> watchdog_active_out)
    else $error("watchdog not active after enable with option set");

  wdt_off_a: assert property (wr_sfr && !io_wdata_in[`PMC_SFR_WTE] |=> !watchdog_active_out)
    else $error("watchdog active after enable bit cleared");

  dual_write_a: assert property (wr_sfr |=> dual_clock_normal_out == $past(io_wdata_in[`PMC_SFR_DUAL]))
    else $error("dual clock bit did not take the written bit");

  mask_write_a: assert property (wr_imr |=> irq_mask_out == $past(io_wdata_in))
    else $error("interrupt mask did not take the written byte");

  flag_set_a: assert property (irq_event_in[7] |=> irq_flags_out[7])
    else $error("low pattern flag not set by its event");

  flag_clear_a: assert property (irq_flag_clr_in[0] && !irq_event_in[0] |=> !irq_flags_out[0])
    else $error("timer flag not cleared by firmware");

  resume_flag_a: assert property (irq_event_in[`PMC_IRQ_HOST_RESUME] && !dual_clock_normal_out |=>
    irq_flags_out[`PMC_IRQ_HOST_RESUME])
    else $error("host resume flag not set in slow clock mode");

  resume_run_a: assert property (udc_resume_in && !run_out |=> run_out)
    else $error("controller resume did not wake the core");

  unmapped_read_a: assert property (io_rd_in && io_addr_in < `PMC_ADDR_DIR7 |=> io_rdata_out == 8'h00)
    else $error("unmapped address did not read zero");

  mode_read_a: assert property (io_rd_in && io_addr_in == `PMC_ADDR_MODE |=> io_rdata_out[5:2] == 4'h0)
    else $error("mode register unused bits read nonzero");

  sfr_fixed_a: assert property (sfr[3] == 1'b0 && sfr[1:0] == 2'h0)
    else $error("special function unused bits not zero");

  gie_gate_a: assert property (!gie |-> !irq_req_out)
    else $error("interrupt requested while globally disabled");

  irq_masked_a: assert property ((irq_flags_out & irq_mask_out) == 8'h00 |-> !irq_req_out)
    else $error("interrupt requested with no enabled flag");

  gie_on_a: assert property (global_irq_on_instr_in && !global_irq_off_instr_in |=> gie)
    else $error("global enable not set by enable instruction");

endmodule // pmc_port_mode_ctrl_regs

// >>> design/pmc_map.svh
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ****************************************
// Control register addresses
// ****************************************
`define PMC_ADDR_DIR7 4'h7
`define PMC_ADDR_SINK 4'h8
`define PMC_ADDR_PAT 4'h9
`define PMC_ADDR_MODE 4'hA
`define PMC_ADDR_PL6 4'hB
`define PMC_ADDR_PH6 4'hC
`define PMC_ADDR_PH7 4'hD
`define PMC_ADDR_SFR 4'hE
`define PMC_ADDR_IMR 4'hF

// ****************************************
// Power-on values
// ****************************************
`define PMC_RST_DIR7 8'hFF
`define PMC_RST_SINK 8'h00
`define PMC_RST_PAT 8'h70
`define PMC_RST_MODE 8'hC0
`define PMC_RST_PL6 8'h00
`define PMC_RST_PH6 8'h00
`define PMC_RST_PH7 8'h00
`define PMC_RST_SFR 8'hF0
`define PMC_RST_IMR 8'h00
`define PMC_RST_GIE 1'b1

// ****************************************
// Writable bit masks
// ****************************************
`define PMC_WM_FULL 8'hFF
`define PMC_WM_SINK 8'h33
`define PMC_WM_PAT 8'h77
`define PMC_WM_MODE 8'hC3
`define PMC_WM_PORT6 8'hFE
`define PMC_WM_SFR 8'hF4

// ****************************************
// Field positions
// ****************************************
`define PMC_SFR_PDA 2
`define PMC_SFR_RUN 4
`define PMC_SFR_WTE 5
`define PMC_SFR_WUB 6
`define PMC_SFR_DUAL 7
`define PMC_IRQ_HOST_RESUME 4

`endif

// >>> design/pmc_pkg.sv
package pmc_pkg;

  typedef logic [7:0] pmc_byte_type;
  typedef logic [3:0] pmc_addr_type;

  typedef enum logic [1:0] {
    PMC_MODE_DETECT = 2'h0,
    PMC_MODE_USB = 2'h1,
    PMC_MODE_PS2 = 2'h2,
    PMC_MODE_USB_TEST = 2'h3
  } pmc_opmode_type;

  typedef enum logic [1:0] {
    PMC_SLOW_500HZ = 2'h0,
    PMC_SLOW_4KHZ = 2'h1,
    PMC_SLOW_32KHZ = 2'h2,
    PMC_SLOW_256KHZ = 2'h3
  } pmc_slow_freq_type;

  typedef enum logic [1:0] {
    PMC_SINK_3MA = 2'h0,
    PMC_SINK_6MA = 2'h1,
    PMC_SINK_12MA = 2'h2,
    PMC_SINK_30MA = 2'h3
  } pmc_sink_type;

endpackage : pmc_pkg

// >>> dv/pmc_port_mode_ctrl_regs_bench.sv
module pmc_port_mode_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_in, rstn_in, io_wr_in, io_rd_in, gon, goff, wakeup_in, udc_resume_in, blk, wdo;
  pmc_addr_type io_addr_in;
  pmc_byte_type io_wdata_in, io_rdata_out, irq_event_in, irq_flag_clr_in;
  pmc_byte_type dir_o, pl_o, ph6_o, ph7_o, mask_o, flags_o;
  pmc_sink_type s0_o, s1_o;
  pmc_opmode_type mode_o;
  pmc_slow_freq_type slow_o;
  logic [2:0] db_o, sr_o;
  logic pda_o, run_o, wd_o, wbn_o, dual_o, irq_o;
  int fail_count, num_checks, cycles, seed;
  pmc_byte_type d, e;

  pmc_port_mode_ctrl_regs DUT (.clk_in(clk_in), .rstn_in(rstn_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .global_irq_on_instr_in(gon), .global_irq_off_instr_in(goff), .irq_event_in(irq_event_in),
    .irq_flag_clr_in(irq_flag_clr_in), .wakeup_in(wakeup_in), .udc_resume_in(udc_resume_in),
    .usb_device_controller_block_in(blk), .watchdog_code_option_in(wdo), .port7_dir_out(dir_o),
    .first_pin_drive_out(s0_o), .second_pin_drive_out(s1_o), .debounce_degree_out(db_o),
    .sample_rate_sel_out(sr_o), .op_mode_out(mode_o), .slow_freq_sel_out(slow_o),
    .pull_low_select_out(pl_o), .port6_pull_high_out(ph6_o), .pull_high_select_out(ph7_o),
    .pattern_detect_enable_out(pda_o), .run_out(run_o), .watchdog_active_out(wd_o),
    .port_wake_block_n_out(wbn_o), .dual_clock_normal_out(dual_o), .irq_mask_out(mask_o),
    .irq_flags_out(flags_o), .irq_req_out(irq_o));

  // ****************************************
  // Expectation tables
  // ****************************************
  function automatic pmc_byte_type wmask(input pmc_addr_type a);
    case (a)
      4'h8: wmask = 8'h33;
      4'h9: wmask = 8'h77;
      4'hA: wmask = 8'hC3;
      4'hB, 4'hC: wmask = 8'hFE;
      4'hE: wmask = 8'hF4;
      4'h7, 4'hD, 4'hF: wmask = 8'hFF;
      default: wmask = 8'h00;
    endcase
  endfunction

  function automatic pmc_byte_type rstv(input pmc_addr_type a);
    case (a)
      4'h7: rstv = 8'hFF;
      4'h9: rstv = 8'h70;
      4'hA: rstv = 8'hC0;
      4'hE: rstv = 8'hF0;
      default: rstv = 8'h00;
    endcase
  endfunction

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input pmc_addr_type a, input pmc_byte_type v);
    @(posedge clk_in);
    io_wr_in <= 1'b1;
    io_addr_in <= a;
    io_wdata_in <= v;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input pmc_addr_type a, input pmc_byte_type exp);
    @(posedge clk_in);
    io_rd_in <= 1'b1;
    io_addr_in <= a;
    @(posedge clk_in);
    io_rd_in <= 1'b0;
    #1;
    check("rdata", io_rdata_out, exp);
  endtask

  task automatic ev(input pmc_byte_type v, input pmc_byte_type c);
    @(posedge clk_in);
    irq_event_in <= v;
    irq_flag_clr_in <= c;
    @(posedge clk_in);
    irq_event_in <= 8'h00;
    irq_flag_clr_in <= 8'h00;
    #1;
  endtask

  // ****************************************
  // Clock, reset and timeout
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rstn_in, io_wr_in, io_rd_in, gon, goff, udc_resume_in, blk, wdo} = 8'h00;
    wakeup_in = 1'b1;
    io_addr_in = 4'h0;
    io_wdata_in = 8'h00;
    irq_event_in = 8'h00;
    irq_flag_clr_in = 8'h00;
    seed = 5732;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a[3:0], rstv(a[3:0]));
    check("sink", {s1_o, s0_o}, 4'h0);
    check("rate", sr_o, 3'h7);
    check("wdog", wd_o, 1'b0);
    for (int it = 0; it < 12; it++) begin
      for (int a = 7; a < 16; a++) begin
        d = (it < 4) ? {4{it[1:0]}} : pmc_byte_type'($random(seed));
        if (a == 14) d[4] = 1'b1;
        e = d & wmask(a[3:0]);
        wr(a[3:0], d);
        case (a)
          7: check("dir", dir_o, e);
          8: check("drive", {s1_o, s0_o}, {e[5:4], e[1:0]});
          9: check("pat", {sr_o, db_o}, {e[6:4], e[2:0]});
          10: check("mode", {slow_o, mode_o}, {e[7:6], e[1:0]});
          11: check("pl6", pl_o, e);
          12: check("ph6", ph6_o, e);
          13: check("ph7", ph7_o, e);
          14: check("sfr", {dual_o, wbn_o, run_o, pda_o}, {e[7:6], e[4], e[2]});
          default: check("imr", mask_o, e);
        endcase
        rd(a[3:0], e);
      end
    end
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h00);
    // Sleep then wake by falling wake line, then by controller resume
    wr(4'hE, 8'hE0);
    check("run", run_o, 1'b0);
    @(posedge clk_in);
    wakeup_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("run", run_o, 1'b0);
    @(posedge clk_in);
    #1;
    check("run", run_o, 1'b1);
    wakeup_in <= 1'b1;
    wr(4'hE, 8'hA0);
    @(posedge clk_in);
    udc_resume_in <= 1'b1;
    @(posedge clk_in);
    udc_resume_in <= 1'b0;
    #1;
    check("run", run_o, 1'b1);
    check("wbn", wbn_o, 1'b0);
    @(posedge clk_in);
    blk <= 1'b1;
    @(posedge clk_in);
    blk <= 1'b0;
    #1;
    check("wbn", wbn_o, 1'b1);
    // Watchdog gated by code option
    wr(4'hE, 8'hF0);
    repeat (4) @(posedge clk_in);
    #1;
    check("wdog", wd_o, 1'b0);
    wdo <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    check("wdog", wd_o, 1'b1);
    wr(4'hE, 8'hD0);
    @(posedge clk_in);
    #1;
    check("wdog", wd_o, 1'b0);
    // Interrupt sources, host resume only in slow clock
    wr(4'hE, 8'hF0);
    wr(4'hF, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i, 8'h00);
      check("flags", flags_o, (i == 4) ? 8'h00 : (8'h01 << i));
      check("irq", irq_o, i != 4);
      ev(8'h00, 8'hFF);
      check("flags", flags_o, 8'h00);
    end
    wr(4'hE, 8'h70);
    ev(8'h10, 8'h00);
    check("flags", flags_o, 8'h10);
    ev(8'h00, 8'h10);
    wr(4'hE, 8'hF0);
    // Mask and global enable only gate the request
    wr(4'hF, 8'h00);
    ev(8'h01, 8'h00);
    check("flags", flags_o, 8'h01);
    check("irq", irq_o, 1'b0);
    wr(4'hF, 8'h01);
    @(posedge clk_in);
    #1;
    check("irq", irq_o, 1'b1);
    @(posedge clk_in);
    goff <= 1'b1;
    @(posedge clk_in);
    goff <= 1'b0;
    #1;
    check("irq", irq_o, 1'b0);
    check("flags", flags_o, 8'h01);
    @(posedge clk_in);
    gon <= 1'b1;
    @(posedge clk_in);
    gon <= 1'b0;
    #1;
    check("irq", irq_o, 1'b1);
    ev(8'h01, 8'h01);
    check("flags", flags_o, 8'h01);
    // Reset again in mid-run, every register returns to its default
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a[3:0], rstv(a[3:0]));
    check("flags", flags_o, 8'h00);
    check("irq", irq_o, 1'b0);
    finish_test();
  end
endmodule // pmc_port_mode_ctrl_regs_bench
